// ### hdl/hpv_top.sv
// two-wire serial slave with the headphone gain, mute and tristate registers
// assumes scl and sda arrive asynchronously; sda is open drain, driven low only
// =====================================
// What this block does
// - register bit seven mutes left, resets set
// - register bit six mutes right, resets set
// - six-bit gain code, read-write, resets zero
// - tristate register upper six bits read zero
// - bit one tristates left output, resets zero
// - bit zero tristates right output, resets zero
// - revision nibble is constant, writes ignored
// - revision byte upper reserved bits read zero
// - test bytes five to eight read-only, unwritten
// - slave only, answers address 1100000 alone
// - sequential transfers auto-increment register index
`default_nettype none
`include "hpv_regs.svh"
module hpv_top
	import hpv_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// serial pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// amplifier controls
	output hpv_gain_t gain,
	output hpv_tri_t tri_ctl
);
	// =====================================
	// pin synchronisers
	logic scl_s;
	logic sda_s;
	hpv_sync u_scl (.mclk(mclk), .rst_n(rst_n), .pin(scl_in), .level(scl_s));
	hpv_sync u_sda (.mclk(mclk), .rst_n(rst_n), .pin(sda_in), .level(sda_s));

	// =====================================
	// bus condition detection on synchronised levels
	logic scl_d;
	logic sda_d;
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end
		else
		begin
			scl_d <= scl_s;
			sda_d <= sda_s;
		end
	end
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	assign scl_rise = scl_s && !scl_d;
	assign scl_fall = !scl_s && scl_d;
	assign start_c = scl_s && scl_d && sda_d && !sda_s; // also repeated start
	assign stop_c = scl_s && scl_d && !sda_d && sda_s;

	// =====================================
	// byte engine
	hpv_state_t state;
	hpv_state_t next_state;
	hpv_state_t after_ack;
	hpv_state_t next_after_ack;
	logic [7:0] shreg;
	logic [7:0] next_shreg;
	logic [2:0] bitcnt;
	logic [2:0] next_bitcnt;
	logic [7:0] idx;
	logic [7:0] next_idx;
	logic drive_low;
	logic next_drive_low;
	logic reading;
	logic next_reading;
	logic acked;
	logic next_acked;
	// read burst bookkeeping: waiting for the master ack, and ack seen
	// a flag pair rather than a shift-register pattern, so a data byte of all ones
	// can never be mistaken for the end of a byte
	logic mack_wait;
	logic next_mack_wait;
	logic mack_seen;
	logic next_mack_seen;
	hpv_acc_t acc;
	logic [7:0] rdata;

	// byte done on eighth counted edge: rising when receiving, falling when sending
	function automatic logic last_bit(input logic [2:0] c);
		return c == 3'h7;
	endfunction

	// shifting and acknowledge; ack and data bits change on scl falling edges
	always_comb
	begin
		next_state = state;
		next_after_ack = after_ack;
		next_shreg = shreg;
		next_bitcnt = bitcnt;
		next_idx = idx;
		next_drive_low = drive_low;
		next_reading = reading;
		next_acked = acked;
		next_mack_wait = mack_wait;
		next_mack_seen = mack_seen;
		acc = '{wr: 1'b0, rd: 1'b0, addr: idx, data: shreg};
		if (start_c)
		begin
			next_state = HPV_DEVADR;
			next_bitcnt = 3'h0;
			next_drive_low = 1'b0;
			next_mack_wait = 1'b0;
			next_mack_seen = 1'b0;
		end
		else if (stop_c)
		begin
			next_state = HPV_IDLE;
			next_drive_low = 1'b0;
			next_mack_wait = 1'b0;
			next_mack_seen = 1'b0;
		end
		else
		begin
			case (state)
				HPV_DEVADR, HPV_REGIDX, HPV_WDATA:
				begin
					if (scl_rise)
					begin
						next_shreg = {shreg[6:0], sda_s};
						next_bitcnt = bitcnt + 3'h1;
						if (last_bit(bitcnt))
						begin
							next_state = HPV_ACK;
							next_acked = 1'b1;
							if (state == HPV_DEVADR)
							begin
								if (shreg[6:0] != `HPV_DEV_ADDR)
								begin
									next_state = HPV_IGNORE;
									next_acked = 1'b0;
								end
								next_reading = sda_s;
								next_after_ack = sda_s ? HPV_RDATA : HPV_REGIDX;
							end
							else if (state == HPV_REGIDX)
							begin
								next_idx = {shreg[6:0], sda_s};
								next_after_ack = HPV_WDATA;
							end
							else
							begin
								// writes to read-only bytes drop in the regfile
								acc.wr = 1'b1;
								acc.data = {shreg[6:0], sda_s};
								next_idx = idx + 8'h01;
								next_after_ack = HPV_WDATA;
							end
						end
					end
				end
				HPV_ACK:
				begin
					// pull low through the ninth clock, then release, or for a read drive the first byte's msb
					if (scl_fall && !drive_low && acked)
						next_drive_low = 1'b1;
					else if (scl_fall && drive_low)
					begin
						next_drive_low = 1'b0;
						next_state = after_ack;
						next_bitcnt = 3'h0;
						if (after_ack == HPV_RDATA)
						begin
							next_shreg = rdata;
							next_drive_low = !rdata[7];
						end
					end
				end
				HPV_RDATA:
				begin
					if (scl_fall && mack_seen)
					begin
						// next byte: its msb goes out on the fall that ends the master ack,
						// the same place the first byte got its msb from the ack state
						next_mack_seen = 1'b0;
						next_bitcnt = 3'h0;
						next_shreg = rdata;
						next_drive_low = !rdata[7];
					end
					else if (scl_fall && !mack_wait)
					begin
						next_bitcnt = bitcnt + 3'h1;
						next_shreg = {shreg[6:0], 1'b1};
						next_drive_low = last_bit(bitcnt) ? 1'b0 : !shreg[6];
						if (last_bit(bitcnt))
						begin
							// line released so the master can answer
							next_idx = idx + 8'h01;
							next_mack_wait = 1'b1;
						end
					end
					else if (scl_rise && mack_wait)
					begin
						// master ack sampled: ack low continues, nack ends
						next_mack_wait = 1'b0;
						if (sda_s)
							next_state = HPV_IGNORE;
						else
						begin
							acc.rd = 1'b1;
							next_mack_seen = 1'b1;
						end
					end
				end
				default:
				begin
					next_drive_low = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= HPV_IDLE;
			after_ack <= HPV_IDLE;
			shreg <= 8'h00;
			bitcnt <= 3'h0;
			idx <= 8'h00;
			drive_low <= 1'b0;
			reading <= 1'b0;
			acked <= 1'b0;
			mack_wait <= 1'b0;
			mack_seen <= 1'b0;
		end
		else
		begin
			state <= next_state;
			after_ack <= next_after_ack;
			shreg <= next_shreg;
			bitcnt <= next_bitcnt;
			idx <= next_idx;
			drive_low <= next_drive_low;
			reading <= next_reading;
			acked <= next_acked;
			mack_wait <= next_mack_wait;
			mack_seen <= next_mack_seen;
		end
	end

	// open drain: only ever pull low, never drive high
	assign sda_out = 1'b0;
	assign sda_oe = drive_low;

	hpv_regfile u_regs (
		.mclk(mclk),
		.rst_n(rst_n),
		.acc(acc),
		.rdata(rdata),
		.gain(gain),
		.tri_ctl(tri_ctl)
	);

	// =====================================
	// checks
	a_reset_mute: assert property (@(posedge mclk)
		$rose(rst_n) |-> gain.mute_left && gain.mute_right)
		else $error("channels not muted after reset");
	a_no_drive_idle: assert property (@(posedge mclk) disable iff (!rst_n)
		state == HPV_IDLE |-> !sda_oe)
		else $error("sda driven while idle");
	a_wrong_addr: assert property (@(posedge mclk) disable iff (!rst_n)
		state == HPV_IGNORE |=> !sda_oe)
		else $error("ack for foreign address");
	a_idx_step: assert property (@(posedge mclk) disable iff (!rst_n)
		acc.wr |=> idx == $past(idx) + 8'h01)
		else $error("index did not advance");
	// the ninth clock must find the line pulled for our own address
	a_ack_held: assert property (@(posedge mclk) disable iff (!rst_n)
		state == HPV_ACK && scl_rise |-> sda_oe)
		else $error("ack not driven at ninth clock");
	a_read_dir: assert property (@(posedge mclk) disable iff (!rst_n)
		state == HPV_RDATA |-> reading)
		else $error("read data sent for a write");
	// the master owns the line for its ack bit after each read byte
	a_mack_free: assert property (@(posedge mclk) disable iff (!rst_n)
		$rose(mack_wait) |-> !sda_oe)
		else $error("line held during master ack");
	c_write: cover property (@(posedge mclk) acc.wr && acc.addr == `HPV_ADDR_GAIN);
	c_tri: cover property (@(posedge mclk) acc.wr && acc.addr == `HPV_ADDR_TRI);
	c_read: cover property (@(posedge mclk) state == HPV_RDATA);
	c_burst_read: cover property (@(posedge mclk) mack_seen && scl_fall);
	c_foreign: cover property (@(posedge mclk) state == HPV_IGNORE);
endmodule // hpv_top
`default_nettype wire

// ### hdl/hpv_regs.svh
// register addresses, field positions and reset values of the headphone gain bank
// assumes inclusion by bare name from the design modules
`ifndef HPV_REGS_SVH
`define HPV_REGS_SVH
`define HPV_DEV_ADDR 7'h60
`define HPV_ADDR_GAIN 8'h02
`define HPV_ADDR_TRI 8'h03
`define HPV_ADDR_REV 8'h04
`define HPV_ADDR_TEST_FIRST 8'h05
`define HPV_ADDR_TEST_LAST 8'h08
`define HPV_GAIN_RESET 8'hc0
`define HPV_TRI_RESET 2'h0
`define HPV_REV_MASK 8'h0f
`define HPV_TEST_VALUE 8'h00
`endif

// ### hdl/hpv_pkg.sv
// types shared by the headphone gain register bank
// assumes the register header sits beside it
`default_nettype none
package hpv_pkg;
	// =====================================
	// register fields
	typedef struct packed {
		logic mute_left;
		logic mute_right;
		logic [5:0] gain_code;
	} hpv_gain_t;
	typedef struct packed {
		logic left_output_tristate;
		logic right_output_tristate;
	} hpv_tri_t;
	// one register access from the serial front end
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] data;
	} hpv_acc_t;
	typedef enum logic [2:0] {
		HPV_IDLE = 3'h0,
		HPV_DEVADR = 3'h1,
		HPV_REGIDX = 3'h3,
		HPV_WDATA = 3'h2,
		HPV_RDATA = 3'h6,
		HPV_ACK = 3'h7,
		HPV_IGNORE = 3'h5
	} hpv_state_t;
endpackage
`default_nettype wire

// ### hdl/hpv_sync.sv
// two flip-flop synchroniser for the serial pins
// assumes pins are asynchronous to mclk
`default_nettype none
module hpv_sync
	import hpv_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// pin and synchronised level
	input wire logic pin,
	output logic level
);
	logic meta;
	// first stage is read only by the second
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta <= 1'b1;
			level <= 1'b1;
		end
		else
		begin
			meta <= pin;
			level <= meta;
		end
	end
endmodule // hpv_sync

// ### hdl/hpv_regfile.sv
// storage of the gain, mute and tristate fields with read mux
// assumes one access per cycle from the serial slave
`default_nettype none
`include "hpv_regs.svh"
module hpv_regfile
	import hpv_pkg::*;
#(
	parameter logic [3:0] SILICON_REV = 4'h5 // arbitrary value
)
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// access from the serial slave
	input wire hpv_acc_t acc,
	output logic [7:0] rdata,
	// control outputs
	output hpv_gain_t gain,
	output hpv_tri_t tri_ctl
);
	hpv_gain_t next_gain;
	hpv_tri_t next_tri;
	// writes only to the two writable registers; everything else is dropped
	always_comb
	begin
		next_gain = gain;
		next_tri = tri_ctl;
		if (acc.wr && acc.addr == `HPV_ADDR_GAIN)
			next_gain = acc.data;
		else if (acc.wr && acc.addr == `HPV_ADDR_TRI)
			next_tri = acc.data[1:0];
	end
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			gain <= `HPV_GAIN_RESET;
			tri_ctl <= `HPV_TRI_RESET;
		end
		else
		begin
			gain <= next_gain;
			tri_ctl <= next_tri;
		end
	end
	// read mux; revision and test bytes are constants so writes cannot touch them
	always_comb
	begin
		if (acc.addr == `HPV_ADDR_GAIN)
			rdata = gain;
		else if (acc.addr == `HPV_ADDR_TRI)
			rdata = {6'h00, tri_ctl};
		else if (acc.addr == `HPV_ADDR_REV)
			rdata = {4'h0, SILICON_REV} & `HPV_REV_MASK;
		else if (acc.addr >= `HPV_ADDR_TEST_FIRST && acc.addr <= `HPV_ADDR_TEST_LAST)
			rdata = `HPV_TEST_VALUE;
		else
			rdata = 8'h00;
	end
	a_rev_const: assert property (@(posedge mclk) disable iff (!rst_n)
		acc.addr == `HPV_ADDR_REV |-> rdata == {4'h0, SILICON_REV})
		else $error("revision byte wrong");
	a_tri_upper: assert property (@(posedge mclk) disable iff (!rst_n)
		acc.addr == `HPV_ADDR_TRI |-> rdata[7:2] == 6'h00)
		else $error("tristate upper bits nonzero");
	a_gain_write: assert property (@(posedge mclk) disable iff (!rst_n)
		acc.wr && acc.addr == `HPV_ADDR_GAIN |=> gain == $past(acc.data))
		else $error("gain write lost");
	a_gain_hold: assert property (@(posedge mclk) disable iff (!rst_n)
		!(acc.wr && acc.addr == `HPV_ADDR_GAIN) |=> $stable(gain))
		else $error("gain changed without write");
	a_tri_write: assert property (@(posedge mclk) disable iff (!rst_n)
		acc.wr && acc.addr == `HPV_ADDR_TRI |=> tri_ctl == $past(acc.data[1:0]))
		else $error("tristate write lost");
	a_tri_hold: assert property (@(posedge mclk) disable iff (!rst_n)
		!(acc.wr && acc.addr == `HPV_ADDR_TRI) |=> $stable(tri_ctl))
		else $error("tristate changed without write");
	a_test_zero: assert property (@(posedge mclk) disable iff (!rst_n)
		acc.addr == `HPV_ADDR_TEST_LAST |-> rdata == `HPV_TEST_VALUE)
		else $error("test byte nonzero");
endmodule // hpv_regfile
`default_nettype wire

// ### tb/hpv_host.sv
// two-wire bus master model driving the gain register bank
// assumes the bench resolves sda with a pull-up; this model only pulls low
`default_nettype none
module hpv_host
	import hpv_pkg::*;
(
	// clock
	input wire logic mclk,
	// bus lines
	input wire logic sda,
	output logic scl,
	output logic pull
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [6:0] DEV = 7'b1100000;
	logic ok;
	logic [7:0] rx;
	// idle bus: both lines released high
	initial
	begin
		scl = 1'b1;
		pull = 1'b0;
		ok = 1'b1;
	end
	// =====================================
	// bit level, phases of 8 mclk so the pin synchroniser keeps up
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic put_bit(input logic b);
		pull <= ~b;
		tick(4);
		scl <= 1'b1;
		tick(8);
		scl <= 1'b0;
		tick(4);
	endtask
	// sampled mid high phase, clear of the edges where the device moves sda
	task automatic get_bit(output logic b);
		pull <= 1'b0;
		tick(4);
		scl <= 1'b1;
		tick(4);
		b = sda;
		tick(4);
		scl <= 1'b0;
		tick(4);
	endtask
	task automatic start();
		pull <= 1'b0;
		tick(4);
		scl <= 1'b1;
		tick(8);
		pull <= 1'b1;
		tick(8);
		scl <= 1'b0;
		tick(4);
	endtask
	task automatic stop();
		pull <= 1'b1;
		tick(4);
		scl <= 1'b1;
		tick(8);
		pull <= 1'b0;
		tick(8);
	endtask
	// =====================================
	// byte level, msb first
	task automatic put_byte(input logic [7:0] d);
		logic a;
		for (int i = 7; i >= 0; i--)
			put_bit(d[i]);
		get_bit(a);
		ok &= ~a; // the device acks by pulling low
	endtask
	task automatic get_byte(input logic more);
		for (int i = 7; i >= 0; i--)
			get_bit(rx[i]);
		put_bit(~more); // low keeps the burst going
	endtask
	// single byte write; never aimed at the test bytes
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		ok = 1'b1;
		start();
		put_byte({DEV, 1'b0});
		put_byte(idx);
		put_byte(d);
		stop();
	endtask
	// two byte read from idx and idx+1
	task automatic rd(input logic [7:0] idx, output logic [15:0] q);
		ok = 1'b1;
		start();
		put_byte({DEV, 1'b0});
		put_byte(idx);
		start();
		put_byte({DEV, 1'b1});
		get_byte(1'b1);
		q[15:8] = rx;
		get_byte(1'b0);
		q[7:0] = rx;
		stop();
	endtask
endmodule // hpv_host
`default_nettype wire

// ### tb/tb_hpv_top.sv
// self-checking bench for the headphone gain register bank
// assumes the host model and the design under hdl
`default_nettype none
module tb_hpv_top
	import hpv_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [3:0] REV = 4'h5; // arbitrary revision, the design default
	logic mclk;
	logic rst_n;
	logic scl;
	logic pull;
	logic sda_out;
	logic sda_oe;
	wire logic sda;
	hpv_gain_t gain;
	hpv_tri_t tri_ctl;
	int failures;
	int cmp_count;
	logic [15:0] q;
	logic [7:0] gv [5] = '{8'h00, 8'h3f, 8'h80, 8'h41, 8'hd5};
	logic [6:0] bad [4] = '{7'h61, 7'h20, 7'h40, 7'h70};
	// open drain with a pull-up: low when either side pulls
	assign sda = ~pull & (~sda_oe | sda_out);
	hpv_top dut (.mclk(mclk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe(sda_oe), .gain(gain), .tri_ctl(tri_ctl));
	hpv_host host (.mclk(mclk), .sda(sda), .scl(scl), .pull(pull));
	// 200 MHz clock
	initial
	begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	// =====================================
	// compare and verdict
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			failures++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		if (failures == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// =====================================
	// main sequence
	initial
	begin
		rst_n = 1'b0;
		repeat (20) @(posedge mclk);
		chk({gain, 6'h00, tri_ctl}, 16'hc000);
		rst_n <= 1'b1;
		repeat (4) @(posedge mclk);
		host.rd(8'h02, q);
		chk(q, 16'hc000);
		host.rd(8'h04, q);
		chk(q, {4'h0, REV, 8'h00});
		host.rd(8'h07, q);
		chk({q[15:1], host.ok}, 16'h0001);
		chk({15'h0000, sda_out}, 16'h0000);
		// gain and mute table, outputs and read back
		foreach (gv[i])
		begin
			host.wr(8'h02, gv[i]);
			chk({8'h00, gain}, {8'h00, gv[i]});
			host.rd(8'h02, q);
			chk(q, {gv[i], 8'h00});
		end
		// tristate bits with junk in the reserved upper bits
		for (int t = 0; t < 4; t++)
		begin
			host.wr(8'h03, {6'h2a, t[1:0]});
			chk({14'h0, tri_ctl}, {14'h0, t[1:0]});
			host.rd(8'h03, q);
			chk(q, {6'h00, t[1:0], 4'h0, REV});
		end
		// one burst across two registers
		host.ok = 1'b1;
		host.start();
		host.put_byte(8'hc0);
		host.put_byte(8'h02);
		host.put_byte(8'h2a);
		host.put_byte(8'h01);
		host.stop();
		chk({host.ok, gain, 5'h00, tri_ctl}, 16'h9501);
		host.wr(8'h04, 8'hdf);
		host.rd(8'h04, q);
		chk(q, {4'h0, REV, 8'h00});
		// foreign device addresses must be ignored
		foreach (bad[i])
		begin
			host.ok = 1'b1;
			host.start();
			host.put_byte({bad[i], 1'b0});
			host.put_byte(8'h02);
			host.put_byte(8'h00);
			host.stop();
			chk({7'h00, host.ok, gain}, 16'h002a);
		end
		// reset in mid run
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		chk({gain, 6'h00, tri_ctl}, 16'hc000);
		rst_n <= 1'b1;
		repeat (4) @(posedge mclk);
		host.rd(8'h02, q);
		chk(q, 16'hc000);
		final_report();
	end
endmodule // tb_hpv_top
`default_nettype wire
